// file: verilog/flyback_seq_map.svh
// timing constants and reset values of the flyback protection sequencer
`ifndef FLYBACK_SEQ_MAP_SVH
`define FLYBACK_SEQ_MAP_SVH
`define CLK_PERIOD_NS 50
`define HI_BLANK_US 50
`define LO_BLANK_US 350
`define HI_BLANK_CYC ((`HI_BLANK_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LO_BLANK_CYC ((`LO_BLANK_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_TIMER_MS 128
`define AUTOREC_MS 1000
`define WATCHDOG_MS 32
`define SSTART_MS 4
`define MS_CYC (1000000 / `CLK_PERIOD_NS)
`define FAULT_CYC (`FAULT_TIMER_MS * `MS_CYC)
`define AUTOREC_CYC (`AUTOREC_MS * `MS_CYC)
`define WATCHDOG_CYC (`WATCHDOG_MS * `MS_CYC)
`define SSTART_CYC (`SSTART_MS * `MS_CYC)
`define SS_STEPS 15
`define FREQ_STEP_NOM 4'hf
`define FREQ_STEP_MIN 4'h0
`define CTRL_ADDR 12'h000
`define STAT_ADDR 12'h004
`define LINE_ADDR 12'h008
`define CTRL_RESET 32'h0000_0001
`define CTRL_LATCHED_BIT 0
`define CTRL_FOLD_BIT 1
`endif

// file: verilog/flyback_seq_pkg.sv
// types of the flyback protection sequencer
package flyback_seq_pkg;
  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_SOFT = 6'h02,
    ST_RUN = 6'h04,
    ST_SKIP = 6'h08,
    ST_AUTOREC = 6'h10,
    ST_LATCHED = 6'h20
  } seq_state_t;
  typedef struct packed {
    logic feedback_in;
    logic foldback_start;
    logic foldback_done;
    logic skip_in;
    logic skip_out;
    logic comp_enable;
    logic setpoint_at_limit;
    logic max_duty_end;
    logic cs_stop;
    logic line_sense_in;
    logic line_low_level;
    logic latch_high;
    logic latch_low;
    logic supply_turn_on_level;
    logic supply_reset;
    logic thermal_shutdown;
  } sense_t;
  typedef struct packed {
    logic gate_drive_out;
    logic hv_source_en;
    logic soft_start;
    logic boosted_bias;
    logic comp_current_en;
    logic line_sample;
  } drive_t;
endpackage

// file: verilog/flyback_protection_sequencer.sv
// protection and light-load sequencer of a current-mode flyback controller
// Function
// - start fault timer while current setpoint sits at peak limit clamp
// - fault timer elapse stops pulses, then latch off or autorecover
// - clear fault timer when setpoint drops below limit before elapse
// - pulse ended by maximum duty limit also runs fault timer
// - autorecovery waits its delay then restarts, repeating while fault persists
// - compensation current on only while feedback above enable threshold
// - 3-bit line peak sampled then reset on each line-low event
// - without line-low events a 32 ms watchdog makes sample events
// - frequency folds linearly to minimum as feedback falls below start level
// - no frequency foldback while at maximum duty limit
// - feedback at skip entry stops driver in run (not in soft-start), stays until skip exit
// - feedback rising over skip exit resumes driver pulses
// - run only inside latch window, latch off when either edge crossed
// - latch excursions under 50 us high or 350 us low are ignored
// - latched-off released only by brown-out, supply reset or thermal shutdown
// - latch input ignored before turn-on; high latch gates switching start
// - low latch acted on only in run, not during soft-start or skip
// - boosted thermistor bias during soft-start, normal bias otherwise
// - thermal shutdown stops switching, disables start-up source, resets state
// - thermal shutdown clear re-enables source and normal start-up
// - current-sense stop trip enters protection at once
// - soft-start setpoint ramps in 15 steps from zero to limit
// - latched overload released only on brown-out, supply reset or thermal shutdown
`timescale 1ns/1ns
`include "flyback_seq_map.svh"
module flyback_protection_sequencer #(
  parameter int FAULT_CYC = `FAULT_CYC,
  parameter int AUTOREC_CYC = `AUTOREC_CYC,
  parameter int WATCHDOG_CYC = `WATCHDOG_CYC,
  parameter int SSTART_CYC = `SSTART_CYC,
  parameter int HI_BLANK_CYC = `HI_BLANK_CYC,
  parameter int LO_BLANK_CYC = `LO_BLANK_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire flyback_seq_pkg::sense_t sense_in,
  input wire logic [2:0] line_adc_in,
  output flyback_seq_pkg::drive_t drive_out,
  output logic [3:0] ss_step_out,
  output logic [3:0] freq_step_out,
  output logic [2:0] line_code_out,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  flyback_seq_pkg::sense_t sync1_r;
  flyback_seq_pkg::sense_t s_r;
  logic [2:0] adc1_r;
  logic [2:0] adc_r;
  logic line_low_d_r;
  always_ff @(posedge aclk) begin
    sync1_r <= sense_in;
    s_r <= sync1_r;
    adc1_r <= line_adc_in;
    adc_r <= adc1_r;
    line_low_d_r <= s_r.line_low_level;
  end

  wire line_low_evt = s_r.line_low_level & ~line_low_d_r;
  // brown-out or supply reset clears every latch-off
  wire release_evt = s_r.line_low_level | s_r.supply_reset;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_r;
  wire opt_latched = ctrl_r[`CTRL_LATCHED_BIT];
  wire fold_en = ctrl_r[`CTRL_FOLD_BIT];

  // ------------------------------------------------------------
  // latch window blanking
  // ------------------------------------------------------------
  logic [31:0] hi_cnt_r;
  logic [31:0] lo_cnt_r;
  wire hi_trip = (hi_cnt_r >= 32'(HI_BLANK_CYC));
  wire lo_trip = (lo_cnt_r >= 32'(LO_BLANK_CYC));
  always_ff @(posedge aclk) begin
    if (!aresetn || !s_r.latch_high) begin
      hi_cnt_r <= 32'h0;
    end else if (!hi_trip) begin
      hi_cnt_r <= hi_cnt_r + 32'h1;
    end
    if (!aresetn || !s_r.latch_low) begin
      lo_cnt_r <= 32'h0;
    end else if (!lo_trip) begin
      lo_cnt_r <= lo_cnt_r + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // main sequencer
  // ------------------------------------------------------------
  flyback_seq_pkg::seq_state_t state_r;
  flyback_seq_pkg::seq_state_t state_nxt;
  logic [31:0] timer_r;
  logic [31:0] fault_r;
  logic [3:0] ss_step_r;
  logic latch_src_r;
  wire in_soft = (state_r == flyback_seq_pkg::ST_SOFT);
  wire in_run = (state_r == flyback_seq_pkg::ST_RUN);
  wire switching = in_soft | in_run;
  wire overload = s_r.setpoint_at_limit | s_r.max_duty_end;
  wire fault_done = (fault_r >= 32'(FAULT_CYC));
  // protection entered by timer or by the stop comparator at once
  wire protect = switching & (fault_done | s_r.cs_stop);
  // low latch only counts in run, not during soft-start or skip
  wire window_trip = hi_trip | (in_run & lo_trip);
  wire ss_done = (ss_step_r == 4'(`SS_STEPS)) && (timer_r >= 32'(SSTART_CYC / `SS_STEPS));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      flyback_seq_pkg::ST_OFF: begin
        // high latch evaluated at turn-on, low latch ignored here;
        // a held brown-out or supply reset keeps it off instead of bouncing
        if (s_r.supply_turn_on_level && s_r.line_sense_in && !hi_trip &&
            !s_r.line_low_level && !s_r.supply_reset) begin
          state_nxt = flyback_seq_pkg::ST_SOFT;
        end else if (s_r.supply_turn_on_level && hi_trip) begin
          state_nxt = flyback_seq_pkg::ST_LATCHED;
        end
      end
      flyback_seq_pkg::ST_SOFT: begin
        if (ss_done) begin
          state_nxt = flyback_seq_pkg::ST_RUN;
        end
      end
      flyback_seq_pkg::ST_RUN: begin
        if (s_r.skip_in) begin
          state_nxt = flyback_seq_pkg::ST_SKIP;
        end
      end
      flyback_seq_pkg::ST_SKIP: begin
        if (s_r.skip_out) begin
          state_nxt = flyback_seq_pkg::ST_RUN;
        end
      end
      flyback_seq_pkg::ST_AUTOREC: begin
        if (timer_r >= 32'(AUTOREC_CYC)) begin
          state_nxt = flyback_seq_pkg::ST_OFF;
        end
      end
      flyback_seq_pkg::ST_LATCHED: begin
        if (release_evt) begin
          state_nxt = flyback_seq_pkg::ST_OFF;
        end
      end
      default: state_nxt = flyback_seq_pkg::ST_OFF;
    endcase
    if (state_r != flyback_seq_pkg::ST_LATCHED && state_r != flyback_seq_pkg::ST_OFF &&
        window_trip) begin
      state_nxt = flyback_seq_pkg::ST_LATCHED;
    end else if (protect) begin
      state_nxt = opt_latched ? flyback_seq_pkg::ST_LATCHED
                              : flyback_seq_pkg::ST_AUTOREC;
    end
    if (state_r != flyback_seq_pkg::ST_OFF && s_r.line_low_level &&
        state_r != flyback_seq_pkg::ST_LATCHED) begin
      state_nxt = flyback_seq_pkg::ST_OFF;
    end
  end

  always_ff @(posedge aclk) begin
    // thermal shutdown resets state, timer and soft-start step, restart follows from off
    if (!aresetn || s_r.thermal_shutdown) begin
      state_r <= flyback_seq_pkg::ST_OFF;
      timer_r <= 32'h0;
      ss_step_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        timer_r <= 32'h0;
        ss_step_r <= 4'h0;
      end else if (in_soft && ss_step_r != 4'(`SS_STEPS) &&
                   timer_r >= 32'(SSTART_CYC / `SS_STEPS)) begin
        timer_r <= 32'h0;
        ss_step_r <= ss_step_r + 4'h1;
      end else if (!ss_done) begin
        timer_r <= timer_r + 32'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || s_r.thermal_shutdown || !switching || !overload) begin
      fault_r <= 32'h0;
    end else if (!fault_done) begin
      fault_r <= fault_r + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // line sampling for overpower compensation
  // ------------------------------------------------------------
  logic [31:0] wd_r;
  logic [2:0] line_code_r;
  logic sample_r;
  wire wd_evt = (wd_r >= 32'(WATCHDOG_CYC) - 32'h1);
  wire sample_evt = line_low_evt | wd_evt;
  always_ff @(posedge aclk) begin
    if (!aresetn || sample_evt) begin
      wd_r <= 32'h0;
    end else begin
      wd_r <= wd_r + 32'h1;
    end
    if (!aresetn) begin
      line_code_r <= 3'h0;
      sample_r <= 1'b0;
    end else begin
      if (sample_evt) begin
        line_code_r <= adc_r;
      end
      sample_r <= sample_evt;
    end
  end

  // ------------------------------------------------------------
  // frequency foldback
  // ------------------------------------------------------------
  logic [3:0] freq_r;
  wire fold_hold = s_r.max_duty_end;
  always_ff @(posedge aclk) begin
    if (!aresetn || !s_r.foldback_start || fold_hold || !fold_en) begin
      freq_r <= `FREQ_STEP_NOM;
    end else if (s_r.foldback_done) begin
      freq_r <= `FREQ_STEP_MIN;
    end else if (freq_r != `FREQ_STEP_MIN && wd_r[9:0] == 10'h0) begin
      freq_r <= freq_r - 4'h1;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drive_out <= '0;
      ss_step_out <= 4'h0;
      freq_step_out <= `FREQ_STEP_NOM;
      line_code_out <= 3'h0;
    end else begin
      drive_out.gate_drive_out <= switching && (state_nxt == state_r) &&
                                  !s_r.thermal_shutdown;
      drive_out.hv_source_en <= !s_r.thermal_shutdown && s_r.line_sense_in &&
                                !s_r.supply_turn_on_level;
      drive_out.soft_start <= in_soft;
      drive_out.boosted_bias <= in_soft;
      drive_out.comp_current_en <= s_r.comp_enable && switching;
      drive_out.line_sample <= sample_r;
      ss_step_out <= in_soft ? ss_step_r : 4'(`SS_STEPS);
      freq_step_out <= freq_r;
      line_code_out <= line_code_r;
    end
  end

  // ------------------------------------------------------------
  // axi4-lite slave; write needs both address and data present
  // ------------------------------------------------------------
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (s_axi_awaddr == `CTRL_ADDR) && s_axi_wstrb[0];
  wire rd_go = s_axi_arvalid && !s_axi_rvalid;
  wire rd_ctrl = (s_axi_araddr == `CTRL_ADDR);
  wire rd_stat = (s_axi_araddr == `STAT_ADDR);
  wire rd_line = (s_axi_araddr == `LINE_ADDR);
  wire [31:0] rd_val = rd_ctrl ? ctrl_r :
                       rd_stat ? {26'h0, state_r} :
                       rd_line ? {21'h0, freq_r, ss_step_r, line_code_r} : 32'h0;
  wire rd_ok = rd_ctrl | rd_stat | rd_line;
  wire wr_ok = (s_axi_awaddr == `CTRL_ADDR) | (s_axi_awaddr == `STAT_ADDR) |
               (s_axi_awaddr == `LINE_ADDR);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= `CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_awready <= wr_go && !s_axi_awready;
      s_axi_wready <= wr_go && !s_axi_awready;
      if (wr_go && !s_axi_awready) begin
        if (wr_ctrl) begin
          ctrl_r <= {30'h0, s_axi_wdata[1:0]};
        end
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rd_go && !s_axi_arready;
      if (rd_go && !s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: dv/flyback_env_model.sv
// far-side model: feedback level, max-duty pulse ending and the other comparators
`timescale 1ns/1ns
module flyback_env_model (
  input wire logic aclk,
  input wire logic [2:0] fb_level,
  input wire flyback_seq_pkg::sense_t base,
  input wire flyback_seq_pkg::drive_t drive_out,
  output flyback_seq_pkg::sense_t sense_out
);
  // thresholds rise in this order so the levels stay consistent:
  // skip entry < skip exit < fold end < fold start < comp enable < limit
  always_comb begin
    sense_out = base;
    sense_out.skip_in = fb_level == 3'h0;
    sense_out.skip_out = fb_level >= 3'h2;
    sense_out.foldback_done = fb_level <= 3'h2;
    sense_out.foldback_start = fb_level <= 3'h3;
    sense_out.comp_enable = fb_level >= 3'h5;
    sense_out.setpoint_at_limit = fb_level >= 3'h6;
    // the pulse can only end at max duty while the switch is driven
    sense_out.max_duty_end = drive_out.gate_drive_out && fb_level == 3'h7;
  end
endmodule

// file: dv/flyback_seq_sva.sv
// port checker of the flyback protection sequencer
`timescale 1ns/1ns
module flyback_seq_sva #(
  parameter int FAULT_CYC = 200,
  parameter int WATCHDOG_CYC = 500,
  parameter int HI_BLANK_CYC = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire flyback_seq_pkg::sense_t sense_in,
  input wire flyback_seq_pkg::drive_t drive_out,
  input wire logic [3:0] ss_step_out,
  input wire logic [3:0] freq_step_out
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ---------------------------------------------------------------
  // helper counters; slack covers the two-flop input synchroniser
  // ---------------------------------------------------------------
  int flt_c;
  int hi_c;
  int wd_c;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_c <= 0;
      hi_c <= 0;
      wd_c <= 0;
    end else begin
      flt_c <= (drive_out.gate_drive_out && sense_in.setpoint_at_limit) ? flt_c + 1 : 0;
      hi_c <= (drive_out.gate_drive_out && sense_in.latch_high) ? hi_c + 1 : 0;
      wd_c <= (drive_out.line_sample || sense_in.thermal_shutdown) ? 0 : wd_c + 1;
    end
  end
  a_tsd_off: assert property (sense_in.thermal_shutdown [*4] |=>
    !drive_out.gate_drive_out && !drive_out.hv_source_en) else $error("drive on in shutdown");
  a_cs_stop_off: assert property (sense_in.cs_stop [*4] |=>
    !drive_out.gate_drive_out) else $error("drive on after cs stop");
  a_fault_bound: assert property (flt_c <= FAULT_CYC + 5)
    else $error("fault timer never elapsed");
  a_latch_hi_bound: assert property (hi_c <= HI_BLANK_CYC + 5)
    else $error("high latch ignored");
  a_wd_bound: assert property (wd_c <= WATCHDOG_CYC + 6)
    else $error("no watchdog sample");
  a_sample_pulse: assert property (drive_out.line_sample |=> !drive_out.line_sample)
    else $error("sample pulse too long");
  a_bias_soft: assert property (drive_out.boosted_bias == drive_out.soft_start)
    else $error("bias not tied to soft-start");
  a_comp_off: assert property ((!sense_in.comp_enable) [*4] |=>
    !drive_out.comp_current_en) else $error("compensation on at light load");
  a_fold_inhibit: assert property (sense_in.max_duty_end [*4] |=>
    freq_step_out == 4'hf) else $error("foldback at max duty");
  a_skip_stop: assert property ((sense_in.skip_in && !sense_in.skip_out &&
    !drive_out.soft_start) [*4] |=> !drive_out.gate_drive_out || drive_out.soft_start)
    else $error("drive on in skip");
  a_ss_rise: assert property (drive_out.soft_start && $past(drive_out.soft_start) |->
    ss_step_out >= $past(ss_step_out)) else $error("soft-start step fell");
endmodule
bind flyback_protection_sequencer flyback_seq_sva #(.FAULT_CYC(FAULT_CYC),
  .WATCHDOG_CYC(WATCHDOG_CYC), .HI_BLANK_CYC(HI_BLANK_CYC)) i_sva (.aclk(aclk),
  .aresetn(aresetn), .sense_in(sense_in), .drive_out(drive_out),
  .ss_step_out(ss_step_out), .freq_step_out(freq_step_out));

// file: dv/tb.sv
// self-checking bench of the flyback protection sequencer
`timescale 1ns/1ns
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [3:0] s_axi_wstrb, ss_step_out, freq_step_out;
  logic [2:0] fb, line_adc_in, line_code_out;
  flyback_seq_pkg::sense_t env, sense_in;
  flyback_seq_pkg::drive_t drive_out;
  int mismatches, compares, n;
  flyback_env_model i_env (.aclk, .fb_level(fb), .base(env), .drive_out, .sense_out(sense_in));
  flyback_protection_sequencer #(.FAULT_CYC(200), .AUTOREC_CYC(300), .WATCHDOG_CYC(500),
    .SSTART_CYC(150), .HI_BLANK_CYC(10), .LO_BLANK_CYC(20)) i_dut (.aclk, .aresetn,
    .sense_in, .line_adc_in, .drive_out, .ss_step_out, .freq_step_out, .line_code_out,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // polls the one-hot state word under a bound
  task automatic wst(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      rd(12'h004);
      n++;
    end while (rv !== exp && n < 800);
    chk(rv, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    aresetn = 1'b0;
    env = '0;
    fb = 3'h5;
    line_adc_in = 3'h5;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    cyc(2);
    aresetn <= 1'b1;
    rd(12'h000);
    chk(rv, 32'h1);
    wst(32'h1);
    s_axi_wstrb <= 4'h0;
    wr(12'h000, 32'h0);
    chk(rs, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(12'h000);
    chk(rv, 32'h1);
    rd(12'h00c);
    chk(rs, 2'h2);
    wr(12'h010, 32'h0);
    chk(rs, 2'h2);
    env.supply_turn_on_level <= 1'b1;
    env.line_sense_in <= 1'b1;
    wst(32'h2);
    chk(drive_out.boosted_bias, 1'b1);
    wst(32'h4);
    chk(ss_step_out, 4'hf);
    chk(drive_out.comp_current_en, 1'b1);
    chk(drive_out.boosted_bias, 1'b0);
    fb <= 3'h0;
    wst(32'h8);
    fb <= 3'h1;
    cyc(20);
    rd(12'h004);
    chk(rv, 32'h8);
    chk(drive_out.gate_drive_out, 1'b0);
    fb <= 3'h2;
    wst(32'h4);
    chk(drive_out.gate_drive_out, 1'b1);
    fb <= 3'h3;
    wr(12'h000, 32'h3);
    // steps land on watchdog wraps, so wait for the first one and time from it
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (freq_step_out === 4'hf && n < 2000);
    cyc(400);
    chk(freq_step_out, 4'he);
    cyc(200);
    chk(freq_step_out, 4'hd);
    fb <= 3'h2;
    cyc(10);
    chk(freq_step_out, 4'h0);
    fb <= 3'h7;
    cyc(10);
    chk(freq_step_out, 4'hf);
    wst(32'h20);
    env.line_low_level <= 1'b1;
    wst(32'h1);
    chk(line_code_out, 3'h5);
    fb <= 3'h5;
    env.line_low_level <= 1'b0;
    wr(12'h000, 32'h0);
    wst(32'h4);
    fb <= 3'h6;
    cyc(150);
    fb <= 3'h5;
    cyc(20);
    fb <= 3'h6;
    cyc(150);
    rd(12'h004);
    chk(rv, 32'h4);
    wst(32'h10);
    wst(32'h2);
    wst(32'h10);
    fb <= 3'h5;
    wst(32'h4);
    env.cs_stop <= 1'b1;
    cyc(6);
    rd(12'h004);
    chk(rv, 32'h10);
    env.cs_stop <= 1'b0;
    wst(32'h4);
    env.latch_high <= 1'b1;
    cyc(5);
    env.latch_high <= 1'b0;
    cyc(20);
    rd(12'h004);
    chk(rv, 32'h4);
    env.latch_high <= 1'b1;
    cyc(20);
    wst(32'h20);
    env.latch_high <= 1'b0;
    env.supply_reset <= 1'b1;
    wst(32'h1);
    env.supply_reset <= 1'b0;
    env.latch_low <= 1'b1;
    wst(32'h2);
    cyc(60);
    rd(12'h004);
    chk(rv, 32'h2);
    wst(32'h20);
    env.latch_low <= 1'b0;
    env.line_low_level <= 1'b1;
    wst(32'h1);
    env.line_low_level <= 1'b0;
    wst(32'h2);
    env.thermal_shutdown <= 1'b1;
    env.supply_turn_on_level <= 1'b0;
    wst(32'h1);
    chk(drive_out.hv_source_en, 1'b0);
    env.thermal_shutdown <= 1'b0;
    cyc(10);
    chk(drive_out.hv_source_en, 1'b1);
    env.supply_turn_on_level <= 1'b1;
    wst(32'h2);
    line_adc_in <= 3'h3;
    cyc(600);
    chk(line_code_out, 3'h3);
    report_and_stop();
  end
endmodule
